/* File: pcs_lpi_fx.sv */
// LPI handling and 100FX 4b/5b coding with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "pcs_lpi_fx_defines.svh"
`default_nettype none
module pcs_lpi_fx #(
  parameter int QUIET_CYC   = 32,
  parameter int REFRESH_CYC = 8,
  parameter int WAKE_W      = 16
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // MAC side
  input  wire logic [3:0]  mac_tx_data,
  input  wire logic        mac_tx_en,
  input  wire logic        mac_tx_lpi,
  output logic [3:0]       mac_rx_data,
  output logic             mac_rx_dv,
  output logic             mac_rx_lpi,
  // Line side
  output logic [4:0]       line_tx_code,
  output logic             serdes_tx_halt,
  input  wire logic [4:0]  line_rx_code,
  input  wire logic        line_rx_valid,
  input  wire logic        serdes_sd,
  input  wire logic        gpio_sd
);

  // 4b/5b encode
  function automatic logic [4:0] enc(input logic [3:0] n);
    logic [4:0] c;
    c = `CG_IDLE;
    case (n)
      4'h0: c = 5'h1E;  4'h1: c = 5'h09;  4'h2: c = 5'h14;  4'h3: c = 5'h15;
      4'h4: c = 5'h0A;  4'h5: c = 5'h0B;  4'h6: c = 5'h0E;  4'h7: c = 5'h0F;
      4'h8: c = 5'h12;  4'h9: c = 5'h13;  4'hA: c = 5'h16;  4'hB: c = 5'h17;
      4'hC: c = 5'h1A;  4'hD: c = 5'h1B;  4'hE: c = 5'h1C;  4'hF: c = 5'h1D;
      default: c = `CG_IDLE;
    endcase
    return c;
  endfunction

  // 4b/5b decode, bit 4 marks a data group
  function automatic logic [4:0] dec(input logic [4:0] c);
    logic [4:0] d;
    d = 5'h00;
    for (int i = 0; i < 16; i++)
      if (enc(4'(i)) == c) d = {1'b1, 4'(i)};
    return d;
  endfunction

  // Register state
  logic              force_tx_low_power;
  logic [6:0]        fiber100_config;
  logic              rx_idle_symbol_seen, tx_idle_symbol_sent;
  logic              far_fault_seen, sync_lost_r;
  logic [WAKE_W-1:0] wake_fail_counter;
  logic              force_nxt, rx_seen_nxt, tx_sent_nxt, fef_nxt, lost_nxt;
  logic [6:0]        fxcfg_nxt;
  logic [WAKE_W-1:0] wake_nxt;
  // Receive and transmit state
  logic                   sync_r, sync_nxt, sd_d_r;
  logic [2:0]             good_r, good_nxt;
  logic                   rx_low_power_active, rx_lpi_nxt;
  logic [3:0]             rxd_nxt;
  logic                   rxdv_nxt;
  pcs_lpi_fx_pkg::tx_lpi_e tx_st_r, tx_st_nxt;
  logic [7:0]             tmr_r, tmr_nxt;
  logic [4:0]             txc_nxt;
  // AXI state
  logic        aw_v_r, w_v_r, aw_v_nxt, w_v_nxt, bv_nxt, rv_nxt;
  logic [7:0]  aw_a_r, aw_a_nxt;
  logic [31:0] wd_r, wd_nxt, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_nxt, rr_nxt;

  logic fx_on, sd_lvl, sd_ok, link_up, lpi_req, code_data, code_lpi, code_bad;
  logic do_wr, do_rd, tx_lpi_sym, tx_lpi_active, tx_quiet, rx_quiet;
  logic [4:0] rx_dec;

  // Signal detect source and polarity
  // source and polarity
  assign fx_on   = fiber100_config[`FXC_ENA];
  assign sd_lvl  = (fiber100_config[`FXC_LOS_SEL] ? gpio_sd : serdes_sd)
                   ^ fiber100_config[`FXC_LOS_POL];
  assign sd_ok   = !fiber100_config[`FXC_LOS_ENA] || sd_lvl;
  assign link_up = sync_r && sd_ok;
  assign rx_dec    = dec(line_rx_code);
  assign code_data = rx_dec[4];
  assign code_lpi  = line_rx_code == `CG_LPI;
  assign code_bad  = !code_data && !code_lpi && line_rx_code != `CG_IDLE
                     && line_rx_code != `CG_FEF;
  assign lpi_req       = mac_tx_lpi || force_tx_low_power;
  assign tx_lpi_active = tx_st_r != pcs_lpi_fx_pkg::TX_ACTIVE;
  assign tx_quiet      = tx_st_r == pcs_lpi_fx_pkg::TX_QUIET;
  assign tx_lpi_sym    = tx_st_r == pcs_lpi_fx_pkg::TX_SLEEP
                         || tx_st_r == pcs_lpi_fx_pkg::TX_REFRESH;
  // quiet while no signal in LPI
  assign rx_quiet      = rx_low_power_active && !sd_lvl;
  assign serdes_tx_halt = tx_quiet;
  assign do_wr = aw_v_r && w_v_r && !s_axi_bvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_v_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_v_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Receive sync surveillance and data
  always_comb
  begin
    good_nxt   = good_r;
    sync_nxt   = sync_r;
    rx_lpi_nxt = rx_low_power_active;
    rxd_nxt    = mac_rx_data;
    rxdv_nxt   = 1'b0;
    if (!sd_ok)
    begin
      good_nxt = 3'd0;
      sync_nxt = 1'b0;
    end
    else if (line_rx_valid)
    begin
      if (code_bad)
      begin
        good_nxt = 3'd0;
        sync_nxt = 1'b0;
      end
      else if (good_r != `SYNC_GOOD)
        good_nxt = good_r + 3'd1;
      else
        sync_nxt = 1'b1;
      if (code_lpi)
        rx_lpi_nxt = 1'b1;
      else if (code_data || line_rx_code == `CG_IDLE)
        rx_lpi_nxt = 1'b0;
      if (code_data && link_up)
      begin
        rxd_nxt  = rx_dec[3:0];
        rxdv_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      good_r              <= 3'd0;
      sync_r              <= 1'b0;
      sd_d_r              <= 1'b0;
      rx_low_power_active <= 1'b0;
      mac_rx_data         <= 4'h0;
      mac_rx_dv           <= 1'b0;
    end
    else
    begin
      good_r              <= good_nxt;
      sync_r              <= sync_nxt;
      sd_d_r              <= sd_lvl;
      rx_low_power_active <= rx_lpi_nxt;
      mac_rx_data         <= rxd_nxt;
      mac_rx_dv           <= rxdv_nxt;
    end
  end
  assign mac_rx_lpi = rx_low_power_active;

  // Transmit LPI state machine and encoder
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    tmr_nxt   = (tmr_r != 8'd0) ? tmr_r - 8'd1 : 8'd0;
    txc_nxt   = `CG_IDLE;
    case (tx_st_r)
      pcs_lpi_fx_pkg::TX_ACTIVE:
        if (lpi_req && !mac_tx_en)
        begin
          tx_st_nxt = pcs_lpi_fx_pkg::TX_SLEEP;
          tmr_nxt   = `SLEEP_CYC;
        end
      pcs_lpi_fx_pkg::TX_SLEEP:
        if (tmr_r == 8'd0)
        begin
          tx_st_nxt = pcs_lpi_fx_pkg::TX_QUIET;
          tmr_nxt   = 8'(QUIET_CYC - 1);
        end
      pcs_lpi_fx_pkg::TX_QUIET:
        if (tmr_r == 8'd0)
        begin
          tx_st_nxt = pcs_lpi_fx_pkg::TX_REFRESH;
          tmr_nxt   = 8'(REFRESH_CYC - 1);
        end
      pcs_lpi_fx_pkg::TX_REFRESH:
        if (tmr_r == 8'd0)
        begin
          tx_st_nxt = pcs_lpi_fx_pkg::TX_QUIET;
          tmr_nxt   = 8'(QUIET_CYC - 1);
        end
      default: tx_st_nxt = pcs_lpi_fx_pkg::TX_ACTIVE;
    endcase
    if (!lpi_req)
      tx_st_nxt = pcs_lpi_fx_pkg::TX_ACTIVE;
    // LPI groups in sleep and refresh
    if (tx_lpi_sym)
      txc_nxt = `CG_LPI;
    else if (fx_on && fiber100_config[`FXC_FEF_GEN] && !link_up)
      txc_nxt = `CG_FEF;
    else if (!tx_lpi_active && mac_tx_en
             && (!fx_on || link_up || fiber100_config[`FXC_ONE_WAY]))
      txc_nxt = enc(mac_tx_data);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_r      <= pcs_lpi_fx_pkg::TX_ACTIVE;
      tmr_r        <= 8'd0;
      line_tx_code <= `CG_IDLE;
    end
    else
    begin
      tx_st_r      <= tx_st_nxt;
      tmr_r        <= tmr_nxt;
      line_tx_code <= txc_nxt;
    end
  end

  // Register writes, stickies and wake counter
  always_comb
  begin
    force_nxt   = force_tx_low_power;
    fxcfg_nxt   = fiber100_config;
    rx_seen_nxt = rx_idle_symbol_seen;
    tx_sent_nxt = tx_idle_symbol_sent;
    fef_nxt     = far_fault_seen;
    lost_nxt    = sync_lost_r;
    wake_nxt    = wake_fail_counter;
    if (do_wr && ws_r[0])
    begin
      if (aw_a_r == `LP_CFG_OFS && !fx_on)
        force_nxt = wd_r[`LP_FORCE_BIT];
      if (aw_a_r == `LP_STATE_OFS && !fx_on)
      begin
        if (wd_r[`LPS_RX_SEEN]) rx_seen_nxt = 1'b0;
        if (wd_r[`LPS_TX_SENT]) tx_sent_nxt = 1'b0;
      end
      if (aw_a_r == `FX_CFG_OFS)
        fxcfg_nxt = wd_r[6:0];
      if (aw_a_r == `FX_STATE_OFS)
      begin
        if (wd_r[`FXS_FEF_SEEN])  fef_nxt  = 1'b0;
        if (wd_r[`FXS_SYNC_LOST]) lost_nxt = 1'b0;
      end
    end
    if (line_rx_valid && code_lpi) rx_seen_nxt = 1'b1;
    if (tx_lpi_sym) tx_sent_nxt = 1'b1;
    if (fx_on && fiber100_config[`FXC_FEF_CHK] && line_rx_valid
        && line_rx_code == `CG_FEF)
      fef_nxt = 1'b1;
    if (fx_on && sync_r && !sync_nxt) lost_nxt = 1'b1;
    if (sd_lvl && !sd_d_r && !sync_r && wake_fail_counter != '1)
      wake_nxt = wake_fail_counter + WAKE_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_tx_low_power  <= 1'b0;
      fiber100_config     <= 7'h00;
      rx_idle_symbol_seen <= 1'b0;
      tx_idle_symbol_sent <= 1'b0;
      far_fault_seen      <= 1'b0;
      sync_lost_r         <= 1'b0;
      wake_fail_counter   <= '0;
    end
    else
    begin
      force_tx_low_power  <= force_nxt;
      fiber100_config     <= fxcfg_nxt;
      rx_idle_symbol_seen <= rx_seen_nxt;
      tx_idle_symbol_sent <= tx_sent_nxt;
      far_fault_seen      <= fef_nxt;
      sync_lost_r         <= lost_nxt;
      wake_fail_counter   <= wake_nxt;
    end
  end

  // AXI4-Lite channel handling and read mux
  always_comb
  begin
    aw_v_nxt = aw_v_r;
    aw_a_nxt = aw_a_r;
    w_v_nxt  = w_v_r;
    wd_nxt   = wd_r;
    ws_nxt   = ws_r;
    bv_nxt   = s_axi_bvalid && !s_axi_bready;
    br_nxt   = s_axi_bresp;
    rv_nxt   = s_axi_rvalid && !s_axi_rready;
    rd_nxt   = s_axi_rdata;
    rr_nxt   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_v_nxt = 1'b1;
      aw_a_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_v_nxt = 1'b1;
      wd_nxt  = s_axi_wdata;
      ws_nxt  = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_v_nxt = 1'b0;
      w_v_nxt  = 1'b0;
      bv_nxt   = 1'b1;
      br_nxt   = (aw_a_r <= `FX_STATE_OFS && aw_a_r[1:0] == 2'b00)
                 ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (do_rd)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `RESP_OKAY;
      rd_nxt = 32'h0000_0000;
      case (s_axi_araddr)
        `LP_CFG_OFS:   rd_nxt[`LP_FORCE_BIT] = force_tx_low_power && !fx_on;
        `LP_STATE_OFS:
          if (!fx_on)
            rd_nxt[5:0] = {tx_idle_symbol_sent, rx_idle_symbol_seen, tx_quiet,
                           tx_lpi_active, rx_quiet, rx_low_power_active};
        `WAKE_CNT_OFS:
          if (!fx_on) rd_nxt[WAKE_W-1:0] = wake_fail_counter;
        `FX_CFG_OFS:   rd_nxt[6:0] = fiber100_config;
        `FX_STATE_OFS: rd_nxt[3:0] = {sync_lost_r, sync_r, sd_lvl, far_fault_seen};
        default:       rr_nxt = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_v_r       <= 1'b0;
      aw_a_r       <= 8'h00;
      w_v_r        <= 1'b0;
      wd_r         <= 32'h0000_0000;
      ws_r         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else
    begin
      aw_v_r       <= aw_v_nxt;
      aw_a_r       <= aw_a_nxt;
      w_v_r        <= w_v_nxt;
      wd_r         <= wd_nxt;
      ws_r         <= ws_nxt;
      s_axi_bvalid <= bv_nxt;
      s_axi_bresp  <= br_nxt;
      s_axi_rvalid <= rv_nxt;
      s_axi_rdata  <= rd_nxt;
      s_axi_rresp  <= rr_nxt;
    end
  end

  // Checks on the LPI and fiber behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_HALT_QUIET: assert property (!lpi_req |=> !serdes_tx_halt)
    else $error("halt outside low power idle");
  AST_REFRESH: assert property (tx_quiet && tmr_r == 8'd0 && lpi_req
    |=> tx_st_r == pcs_lpi_fx_pkg::TX_REFRESH)
    else $error("no refresh after quiet");
  AST_FORCE: assert property (force_tx_low_power && !mac_tx_en && !tx_lpi_active
    |=> tx_lpi_active)
    else $error("force ignored");
  AST_LPI_CODE: assert property (tx_lpi_sym |=> line_tx_code == `CG_LPI)
    else $error("LPI group missing");
  AST_RX_MODE: assert property (line_rx_valid && code_lpi
    |=> rx_low_power_active && mac_rx_lpi)
    else $error("rx mode not entered");
  AST_TX_STICKY: assert property (tx_lpi_sym |=> tx_idle_symbol_sent)
    else $error("tx sticky missing");
  AST_WAKE: assert property (sd_lvl && !sd_d_r && !sync_r && wake_fail_counter != '1
    |=> wake_fail_counter == $past(wake_fail_counter) + WAKE_W'(1))
    else $error("wake counter stuck");
  AST_SYNC_LOST: assert property (fx_on && sync_r && !sync_nxt |=> sync_lost_r)
    else $error("sync loss not recorded");
  AST_SD_RESTART: assert property (fx_on && !sd_ok |=> !sync_r && !mac_rx_dv)
    else $error("no restart on signal loss");
  COV_REFRESH: cover property (tx_quiet ##1 tx_st_r == pcs_lpi_fx_pkg::TX_REFRESH);
  COV_WAKE: cover property (wake_fail_counter != '0);
  COV_FEF: cover property (far_fault_seen);

endmodule // pcs_lpi_fx
`default_nettype wire

/* File: pcs_lpi_fx_defines.svh */
// Offsets, fields, code groups and timing counts of the LPI / 100FX coding block
`ifndef PCS_LPI_FX_DEFINES_SVH
`define PCS_LPI_FX_DEFINES_SVH
`define LP_CFG_OFS    8'h00
`define LP_STATE_OFS  8'h04
`define WAKE_CNT_OFS  8'h08
`define FX_CFG_OFS    8'h0C
`define FX_STATE_OFS  8'h10
`define LP_FORCE_BIT  0
`define LPS_RX_MODE   0
`define LPS_RX_QUIET  1
`define LPS_TX_MODE   2
`define LPS_TX_QUIET  3
`define LPS_RX_SEEN   4
`define LPS_TX_SENT   5
`define FXC_ENA       0
`define FXC_FEF_GEN   1
`define FXC_FEF_CHK   2
`define FXC_LOS_ENA   3
`define FXC_LOS_SEL   4
`define FXC_LOS_POL   5
`define FXC_ONE_WAY   6
`define FXS_FEF_SEEN  0
`define FXS_SIG       1
`define FXS_SYNC      2
`define FXS_SYNC_LOST 3
`define CG_IDLE       5'h1F
`define CG_LPI        5'h08
`define CG_FEF        5'h10
`define SYNC_GOOD     3'd4
`define SLEEP_CYC     8'd4
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* File: pcs_lpi_fx_pkg.sv */
// Types of the LPI / 100FX coding block
`default_nettype none
package pcs_lpi_fx_pkg;
  typedef enum logic [3:0] {
    TX_ACTIVE  = 4'b0001,
    TX_SLEEP   = 4'b0010,
    TX_QUIET   = 4'b0100,
    TX_REFRESH = 4'b1000
  } tx_lpi_e;
endpackage
`default_nettype wire

/* File: line_partner_model.sv */
// Model of the serial transceiver and remote link partner
`default_nettype none
module line_partner_model (
  // Clock
  input  wire logic       aclk,
  // Commands from the bench
  input  wire logic [4:0] send_code,
  input  wire logic       send_valid,
  input  wire logic       sig_on,
  // Toward the block
  output logic [4:0]      line_rx_code,
  output logic            line_rx_valid,
  output logic            serdes_sd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] last_r;

  // Known levels at time zero
  initial
  begin
    last_r        = 5'h00;
    line_rx_code  = 5'h1F;
    line_rx_valid = 1'h0;
    serdes_sd     = 1'h0;
  end

  // One group per clock; an idle line shows the inverted last group
  always @(posedge aclk)
  begin
    line_rx_valid <= send_valid;
    serdes_sd     <= sig_on;
    if (send_valid)
    begin
      line_rx_code <= send_code;
      last_r       <= send_code;
    end
    else
      line_rx_code <= ~last_r;
  end
endmodule // line_partner_model
`default_nettype wire

/* File: pcs_low_power_idle_and_fx100_tb.sv */
// Self-checking bench of the low power idle and fiber coding block
`include "pcs_lpi_fx_defines.svh"
`default_nettype none
module pcs_low_power_idle_and_fx100_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0]  mac_tx_data = 4'h0;
  logic        mac_tx_en = 1'h0;
  logic        mac_tx_lpi = 1'h0;
  logic        gpio_sd = 1'h0;
  logic [3:0]  mac_rx_data;
  logic        mac_rx_dv, mac_rx_lpi, serdes_tx_halt, line_rx_valid, serdes_sd;
  logic [4:0]  line_tx_code, line_rx_code;
  logic [4:0]  send_code = 5'h1F;
  logic        send_valid = 1'h0;
  logic        sig_on = 1'h0;
  logic [31:0] v;
  logic [1:0]  r;
  int          errors = 0;
  int          total_checks = 0;
  logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  // Clock of 4 ns
  always #2 aclk = ~aclk;

  pcs_lpi_fx #(.QUIET_CYC(4), .REFRESH_CYC(2), .WAKE_W(16)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mac_tx_data(mac_tx_data), .mac_tx_en(mac_tx_en), .mac_tx_lpi(mac_tx_lpi),
    .mac_rx_data(mac_rx_data), .mac_rx_dv(mac_rx_dv), .mac_rx_lpi(mac_rx_lpi),
    .line_tx_code(line_tx_code), .serdes_tx_halt(serdes_tx_halt),
    .line_rx_code(line_rx_code), .line_rx_valid(line_rx_valid),
    .serdes_sd(serdes_sd), .gpio_sd(gpio_sd));

  line_partner_model partner_u (
    .aclk(aclk), .send_code(send_code), .send_valid(send_valid), .sig_on(sig_on),
    .line_rx_code(line_rx_code), .line_rx_valid(line_rx_valid), .serdes_sd(serdes_sd));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Let edges pass, then sample settled outputs
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Register write; address and data released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    rs = 2'h3;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (n == 100)
      errors++;
  endtask

  // Register read; data taken at the answering edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    d = 32'h0;
    rs = 2'h3;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (n == 100)
      errors++;
  endtask

  // Read one status bit and compare
  task automatic chk_bit(input logic [7:0] a, input int b, input logic e);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(a, d, rs);
    check({31'h0, d[b]}, {31'h0, e});
  endtask

  // Bounded wait on the transmit halt level
  task automatic wait_halt(input logic e);
    int n;
    n = 0;
    while (serdes_tx_halt !== e && n < 60)
    begin
      ticks(1);
      n++;
    end
    check({31'h0, serdes_tx_halt}, {31'h0, e});
  endtask

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // Signal appears while unsynchronized
    @(posedge aclk);
    sig_on <= 1'h1;
    ticks(4);
    rd(`WAKE_CNT_OFS, v, r);
    check(v, 32'h1);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
    // Queue request for low power idle
    @(posedge aclk);
    mac_tx_lpi <= 1'h1;
    ticks(3);
    check({27'h0, line_tx_code}, {27'h0, `CG_LPI});
    wait_halt(1'h1);
    wait_halt(1'h0);
    wait_halt(1'h1);
    chk_bit(`LP_STATE_OFS, `LPS_TX_MODE, 1'h1);
    chk_bit(`LP_STATE_OFS, `LPS_TX_SENT, 1'h1);
    @(posedge aclk);
    mac_tx_lpi <= 1'h0;
    ticks(3);
    check({27'h0, line_tx_code}, {27'h0, `CG_IDLE});
    chk_bit(`LP_STATE_OFS, `LPS_TX_MODE, 1'h0);
    wr(`LP_STATE_OFS, 32'h1 << `LPS_TX_SENT, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
    chk_bit(`LP_STATE_OFS, `LPS_TX_SENT, 1'h0);
    // Forced low power idle
    wr(`LP_CFG_OFS, 32'h1, r);
    wait_halt(1'h1);
    chk_bit(`LP_CFG_OFS, `LP_FORCE_BIT, 1'h1);
    wr(`LP_CFG_OFS, 32'h0, r);
    ticks(3);
    check({31'h0, serdes_tx_halt}, 32'h0);
    // Partner enters low power idle
    @(posedge aclk);
    send_code <= `CG_LPI;
    send_valid <= 1'h1;
    ticks(4);
    check({31'h0, mac_rx_lpi}, 32'h1);
    chk_bit(`LP_STATE_OFS, `LPS_RX_MODE, 1'h1);
    chk_bit(`LP_STATE_OFS, `LPS_RX_SEEN, 1'h1);
    chk_bit(`LP_STATE_OFS, `LPS_RX_QUIET, 1'h0);
    @(posedge aclk);
    sig_on <= 1'h0;
    ticks(3);
    chk_bit(`LP_STATE_OFS, `LPS_RX_QUIET, 1'h1);
    @(posedge aclk);
    send_code <= `CG_IDLE;
    sig_on <= 1'h1;
    ticks(6);
    check({31'h0, mac_rx_lpi}, 32'h0);
    // Every nibble both ways
    for (int i = 0; i < 16; i++)
    begin
      @(posedge aclk);
      mac_tx_en <= 1'h1;
      mac_tx_data <= 4'(i);
      send_code <= enc[i];
      ticks(3);
      check({27'h0, line_tx_code}, {27'h0, enc[i]});
      check({28'h0, mac_rx_data}, 32'(i));
      check({31'h0, mac_rx_dv}, 32'h1);
    end
    // Fiber mode, masking and link surveillance
    wr(`FX_CFG_OFS, 32'h01, r);
    chk_bit(`LP_STATE_OFS, `LPS_RX_SEEN, 1'h0);
    chk_bit(`FX_STATE_OFS, `FXS_SYNC, 1'h1);
    chk_bit(`FX_STATE_OFS, `FXS_SIG, 1'h1);
    @(posedge aclk);
    send_code <= 5'h00;
    mac_tx_data <= 4'h5;
    ticks(3);
    chk_bit(`FX_STATE_OFS, `FXS_SYNC, 1'h0);
    chk_bit(`FX_STATE_OFS, `FXS_SYNC_LOST, 1'h1);
    check({27'h0, line_tx_code}, {27'h0, `CG_IDLE});
    wr(`FX_CFG_OFS, 32'h41, r);
    ticks(2);
    check({27'h0, line_tx_code}, {27'h0, enc[5]});
    wr(`FX_CFG_OFS, 32'h03, r);
    ticks(2);
    check({27'h0, line_tx_code}, {27'h0, `CG_FEF});
    @(posedge aclk);
    send_code <= `CG_IDLE;
    mac_tx_en <= 1'h0;
    ticks(8);
    chk_bit(`FX_STATE_OFS, `FXS_SYNC, 1'h1);
    wr(`FX_STATE_OFS, 32'h1 << `FXS_SYNC_LOST, r);
    chk_bit(`FX_STATE_OFS, `FXS_SYNC_LOST, 1'h0);
    // Far-end fault from the partner
    wr(`FX_CFG_OFS, 32'h05, r);
    @(posedge aclk);
    send_code <= `CG_FEF;
    ticks(4);
    chk_bit(`FX_STATE_OFS, `FXS_FEF_SEEN, 1'h1);
    // Signal detect source and polarity
    @(posedge aclk);
    sig_on <= 1'h0;
    gpio_sd <= 1'h1;
    send_code <= enc[3];
    wr(`FX_CFG_OFS, 32'h11, r);
    chk_bit(`FX_STATE_OFS, `FXS_SIG, 1'h1);
    wr(`FX_CFG_OFS, 32'h31, r);
    chk_bit(`FX_STATE_OFS, `FXS_SIG, 1'h0);
    wr(`FX_CFG_OFS, 32'h09, r);
    ticks(4);
    check({31'h0, mac_rx_dv}, 32'h0);
    wr(`FX_CFG_OFS, 32'h01, r);
    ticks(8);
    check({31'h0, mac_rx_dv}, 32'h1);
    // Gigabit writes ignored while fiber mode is on
    wr(`LP_CFG_OFS, 32'h1, r);
    wr(`FX_CFG_OFS, 32'h0, r);
    ticks(8);
    check({31'h0, serdes_tx_halt}, 32'h0);
    chk_bit(`LP_CFG_OFS, `LP_FORCE_BIT, 1'h0);
    chk_bit(`LP_STATE_OFS, `LPS_RX_SEEN, 1'h1);
    // Unmapped and unaligned places
    rd(8'h14, v, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    check(v, 32'h0);
    wr(8'h02, 32'h1, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    wrap_up();
  end
endmodule // pcs_low_power_idle_and_fx100_tb
`default_nettype wire
